/* flash_pkg.sv */
package flash_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int N_REQ = 3;
  // Requester slots, index into the one-hot grant
  localparam int SLOT_CPU = 0;
  localparam int SLOT_TEST = 1;
  localparam int SLOT_BOOT = 2;
  // Operation codes
  localparam logic [2:0] OP_PROG_BYTE = 3'h0;
  localparam logic [2:0] OP_PROG_WORD = 3'h1;
  localparam logic [2:0] OP_ERASE_SEG = 3'h2;
  localparam logic [2:0] OP_ERASE_MAIN = 3'h3;
  localparam logic [2:0] OP_ERASE_MASS = 3'h4;
  localparam logic [2:0] OP_READ = 3'h5;
  // Memory map
  localparam logic [15:0] INFO_FIRST = 16'h1000;
  localparam logic [15:0] INFO_LAST = 16'h10FF;
  localparam logic [15:0] MAIN_FIRST = 16'h1100;
  localparam logic [15:0] SEG_A_FIRST = 16'h10C0;
  localparam logic [15:0] SEG_A_LAST = 16'h10FF;
  localparam int MAIN_SEG_BYTES = 512;
  localparam int INFO_SEG_BYTES = 64;
  localparam logic [15:0] MAIN_SEG_MASK = 16'(~(MAIN_SEG_BYTES - 1));
  localparam logic [15:0] INFO_SEG_MASK = 16'(~(INFO_SEG_BYTES - 1));
  localparam logic [7:0] TAG_EMPTY = 8'hFE;
  localparam logic LOCK_A_RESET = 1'b1;
endpackage

/* req_arbiter.sv */
`timescale 1ns/1ps
module req_arbiter
  import flash_pkg::*;
#(
  parameter int N = N_REQ
) (
  input wire logic [N-1:0] req,
  input wire logic enable,
  output logic [N-1:0] grant
);
  // Fixed priority, highest index wins: the test port and boot loader
  // run with the CPU halted, so starvation of the CPU is not a concern.
  always_comb begin
    grant = '0;
    if (enable) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (req[i] && (grant == '0)) begin
          grant[i] = 1'b1;
        end
      end
    end
  end
endmodule

/* flash_segment_control.sv */
`timescale 1ns/1ps
// Summary of operation
// - Program and erase requests are taken from the CPU, the test access port and the serial boot loader.
// - The CPU programs either one byte or one aligned 16-bit word per write.
// - Main flash erases in segments of 512 contiguous bytes.
// - Information flash holds segments A to D, 64 bytes each, each addressed on its own.
// - Main flash erases either all main segments at once or one main segment.
// - Each information segment erases alone, and a mass erase clears info and main together.
// - After any reset segment A is locked against program and erase until software unlocks it.
// - A marginal read mode can be selected to check stored contents.
// - Segment A holds tag-length-value records and a tag of 0xFE marks an empty area.
// - The serial boot loader reaches memory only after the correct user password is given.
module flash_segment_control
  import flash_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [N_REQ-1:0] req_valid,
  input wire logic [3*N_REQ-1:0] req_op,
  input wire logic [ADDR_W*N_REQ-1:0] req_addr,
  input wire logic [DATA_W*N_REQ-1:0] req_wdata,
  output logic [N_REQ-1:0] req_ready,
  output logic [N_REQ-1:0] resp_done,
  output logic resp_error,
  output logic [DATA_W-1:0] resp_rdata,
  output logic resp_tag_empty,
  input wire logic seg_a_unlock,
  input wire logic seg_a_lock,
  output logic seg_a_locked,
  input wire logic [1:0] margin_select,
  input wire logic boot_pw_valid,
  input wire logic [DATA_W-1:0] boot_pw_data,
  input wire logic [DATA_W-1:0] user_password,
  output logic boot_open,
  output logic arr_start,
  output logic [2:0] arr_op,
  output logic [ADDR_W-1:0] arr_addr,
  output logic [DATA_W-1:0] arr_wdata,
  output logic [1:0] arr_margin,
  input wire logic arr_done,
  input wire logic [DATA_W-1:0] arr_rdata
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } state_t;

  typedef struct packed {
    state_t st;
    logic [N_REQ-1:0] owner;
    logic lock_a;
    logic boot_ok;
    logic [1:0] margin;
    logic start;
    logic [2:0] op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [N_REQ-1:0] done;
    logic err;
    logic [DATA_W-1:0] rdata;
    logic tag_empty;
  } ctl_t;

  ctl_t ctl_reg;
  ctl_t ctl_next;
  logic [N_REQ-1:0] grant;
  logic [2:0] g_op;
  logic [ADDR_W-1:0] g_addr;
  logic [DATA_W-1:0] g_wdata;
  logic in_info;
  logic in_main;
  logic hits_a;
  logic refuse;
  logic [ADDR_W-1:0] main_base;

  req_arbiter #(.N(N_REQ)) req_arbiter_i (
    .req(req_valid),
    .enable(ctl_reg.st == ST_IDLE),
    .grant(grant)
  );

  // Select the granted requester's fields
  always_comb begin
    g_op = '0;
    g_addr = '0;
    g_wdata = '0;
    for (int i = 0; i < N_REQ; i++) begin
      if (grant[i]) begin
        g_op = req_op[3*i +: 3];
        g_addr = req_addr[ADDR_W*i +: ADDR_W];
        g_wdata = req_wdata[DATA_W*i +: DATA_W];
      end
    end
  end

  assign in_info = (g_addr >= INFO_FIRST) && (g_addr <= INFO_LAST);
  assign in_main = (g_addr >= MAIN_FIRST);
  assign hits_a = (g_addr >= SEG_A_FIRST) && (g_addr <= SEG_A_LAST);
  // The lowest main segment is cut short by the info area; masking alone would
  // point its erase back into info memory and segment A, so the base is clamped
  assign main_base = ((g_addr & MAIN_SEG_MASK) < MAIN_FIRST) ? MAIN_FIRST : (g_addr & MAIN_SEG_MASK);

  always_comb begin
    refuse = 1'b0;
    case (g_op)
      OP_PROG_BYTE: refuse = !(in_info || in_main);
      OP_PROG_WORD: refuse = !(in_info || in_main) || g_addr[0];
      OP_ERASE_SEG: refuse = !(in_info || in_main);
      OP_ERASE_MAIN: refuse = 1'b0;
      OP_ERASE_MASS: refuse = 1'b0;
      OP_READ: refuse = !(in_info || in_main);
      default: refuse = 1'b1;
    endcase
    // Mass erase would wipe segment A too, so it is refused whole while locked
    if (ctl_reg.lock_a && ((hits_a && (g_op <= OP_ERASE_SEG)) || (g_op == OP_ERASE_MASS))) begin
      refuse = 1'b1;
    end
    if (grant[SLOT_BOOT] && !ctl_reg.boot_ok) begin
      refuse = 1'b1;
    end
  end

  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.start = 1'b0;
    ctl_next.done = '0;
    ctl_next.margin = margin_select;
    // Lock request wins over unlock in the same cycle
    if (seg_a_unlock) begin
      ctl_next.lock_a = 1'b0;
    end
    if (seg_a_lock) begin
      ctl_next.lock_a = 1'b1;
    end
    if (boot_pw_valid) begin
      ctl_next.boot_ok = (boot_pw_data == user_password);
    end
    case (ctl_reg.st)
      ST_IDLE: begin
        if (grant != '0) begin
          if (refuse) begin
            ctl_next.done = grant;
            ctl_next.err = 1'b1;
          end else begin
            ctl_next.st = ST_BUSY;
            ctl_next.owner = grant;
            ctl_next.start = 1'b1;
            ctl_next.op = g_op;
            ctl_next.wdata = (g_op == OP_PROG_BYTE) ? {8'h00, g_wdata[7:0]} : g_wdata;
            ctl_next.addr = g_addr;
            if (g_op == OP_ERASE_SEG) begin
              ctl_next.addr = in_main ? main_base : (g_addr & INFO_SEG_MASK);
            end
          end
        end
      end
      ST_BUSY: begin
        if (arr_done) begin
          ctl_next.st = ST_IDLE;
          ctl_next.done = ctl_reg.owner;
          ctl_next.err = 1'b0;
          ctl_next.rdata = (ctl_reg.op == OP_READ) ? arr_rdata : '0;
          ctl_next.tag_empty = (ctl_reg.op == OP_READ) && (arr_rdata[7:0] == TAG_EMPTY);
        end
      end
      default: ctl_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctl_reg <= '{st: ST_IDLE, lock_a: LOCK_A_RESET, default: '0};
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign req_ready = grant;
  assign resp_done = ctl_reg.done;
  assign resp_error = ctl_reg.err;
  assign resp_rdata = ctl_reg.rdata;
  assign resp_tag_empty = ctl_reg.tag_empty;
  assign seg_a_locked = ctl_reg.lock_a;
  assign boot_open = ctl_reg.boot_ok;
  assign arr_start = ctl_reg.start;
  assign arr_op = ctl_reg.op;
  assign arr_addr = ctl_reg.addr;
  assign arr_wdata = ctl_reg.wdata;
  assign arr_margin = ctl_reg.margin;

  a_lock_after_reset: assert property (@(posedge clock) !rst_b |=> seg_a_locked)
    else $error("segment A not locked after reset");
  a_locked_no_a_op: assert property (@(posedge clock) disable iff (!rst_b)
    arr_start && $past(seg_a_locked) |-> !((arr_addr >= SEG_A_FIRST) && (arr_addr <= SEG_A_LAST) && (arr_op <= OP_ERASE_SEG)))
    else $error("locked segment A was started");
  a_locked_no_mass: assert property (@(posedge clock) disable iff (!rst_b)
    arr_start && $past(seg_a_locked) |-> arr_op != OP_ERASE_MASS)
    else $error("mass erase started while locked");
  a_boot_gate: assert property (@(posedge clock) disable iff (!rst_b)
    grant[SLOT_BOOT] && !boot_open |=> !arr_start && resp_error)
    else $error("boot loader served without password");
  a_word_aligned: assert property (@(posedge clock) disable iff (!rst_b)
    arr_start && arr_op == OP_PROG_WORD |-> !arr_addr[0])
    else $error("odd word program started");
  a_main_seg_base: assert property (@(posedge clock) disable iff (!rst_b)
    arr_start && arr_op == OP_ERASE_SEG && arr_addr >= MAIN_FIRST |-> arr_addr[8:0] == 9'h000 || arr_addr == MAIN_FIRST)
    else $error("main segment erase not aligned");
  a_info_seg_base: assert property (@(posedge clock) disable iff (!rst_b)
    arr_start && arr_op == OP_ERASE_SEG && arr_addr <= INFO_LAST |-> arr_addr[5:0] == 6'h00)
    else $error("info segment erase not aligned");
  a_done_follows: assert property (@(posedge clock) disable iff (!rst_b)
    ctl_reg.st == ST_BUSY && arr_done |=> resp_done == $past(ctl_reg.owner) && !resp_error)
    else $error("array completion not answered");
  a_empty_tag: assert property (@(posedge clock) disable iff (!rst_b)
    ctl_reg.st == ST_BUSY && arr_done && arr_op == OP_READ && arr_rdata[7:0] == TAG_EMPTY |=> resp_tag_empty)
    else $error("empty tag not flagged");
  a_margin_pass: assert property (@(posedge clock) disable iff (!rst_b)
    rst_b |=> arr_margin == $past(margin_select))
    else $error("margin mode not forwarded");
endmodule

/* flash_array_model.sv */
`timescale 1ns/1ps
module flash_array_model
  import flash_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic arr_start,
  input wire logic [ADDR_W-1:0] arr_addr,
  output logic arr_done,
  output logic [DATA_W-1:0] arr_rdata
);
  logic busy = 1'b0;
  logic [1:0] cnt = 2'h0;
  initial arr_done = 1'b0;
  initial arr_rdata = 16'h5A5A;
  // Latency follows the low address bits so both prompt and slow answers occur
  always @(posedge clock) begin
    arr_done <= 1'b0;
    arr_rdata <= ~arr_rdata;
    if (!rst_b) begin
      busy <= 1'b0;
    end else if (arr_start) begin
      busy <= 1'b1;
      cnt <= arr_addr[1:0];
    end else if (busy) begin
      if (cnt == 2'h0) begin
        busy <= 1'b0;
        arr_done <= 1'b1;
        arr_rdata <= {8'hA5, arr_addr[7:0]};
      end else begin
        cnt <= cnt - 2'h1;
      end
    end
  end
endmodule

/* flash_segment_control_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module flash_segment_control_bench;
  import flash_pkg::*;
  logic clock = 0, rst_b = 0, seg_a_unlock = 0, seg_a_lock = 0, boot_pw_valid = 0;
  logic [2:0] req_valid = 0, req_ready, resp_done, arr_op;
  logic [8:0] req_op = 0;
  logic [47:0] req_addr = 0, req_wdata = 0;
  logic resp_error, resp_tag_empty, seg_a_locked, boot_open, arr_start, arr_done;
  logic [15:0] resp_rdata, boot_pw_data = 0, user_password = 16'h3C5A, arr_addr, arr_wdata, arr_rdata;
  logic [1:0] margin_select = 0, arr_margin;
  int n_fail = 0, checks_done = 0;
  always #2.5 clock = ~clock;
  flash_segment_control flash_segment_control_i (.clock, .rst_b, .req_valid, .req_op, .req_addr, .req_wdata,
    .req_ready, .resp_done, .resp_error, .resp_rdata, .resp_tag_empty, .seg_a_unlock, .seg_a_lock, .seg_a_locked,
    .margin_select, .boot_pw_valid, .boot_pw_data, .user_password, .boot_open, .arr_start, .arr_op, .arr_addr,
    .arr_wdata, .arr_margin, .arr_done, .arr_rdata);
  flash_array_model flash_array_model_i (.clock, .rst_b, .arr_start, .arr_addr, .arr_done, .arr_rdata);
  task automatic conclude;
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_for(input int s, input bit rdy);
    for (int k = 0; k < 40; k++) begin
      @(negedge clock);
      if ((rdy ? req_ready[s] : resp_done[s]) === 1'b1) return;
    end
    n_fail++;
    conclude();
  endtask
  // An expected array address of FFFF means the address is not compared
  task automatic run(input int s, input logic [2:0] op, input logic [15:0] a, d, input logic err, input logic [15:0] ea);
    @(posedge clock);
    req_valid[s] <= 1'b1;
    req_op[3*s+:3] <= op;
    req_addr[16*s+:16] <= a;
    req_wdata[16*s+:16] <= d;
    wait_for(s, 1);
    @(posedge clock);
    req_valid[s] <= 1'b0;
    if (!err) begin
      @(negedge clock);
      `CHK("arr_start", 1'b1, arr_start)
      `CHK("arr_op", op, arr_op)
      if (ea !== 16'hFFFF) `CHK("arr_addr", ea, arr_addr)
      if (op == OP_PROG_BYTE) `CHK("arr_wdata", {8'h00, d[7:0]}, arr_wdata)
      if (op == OP_PROG_WORD) `CHK("arr_wdata", d, arr_wdata)
    end
    wait_for(s, 0);
    `CHK("resp_error", err, resp_error)
    if (err) `CHK("arr_start", 1'b0, arr_start)
  endtask
  task automatic pw(input logic [15:0] d, input logic exp);
    @(posedge clock);
    boot_pw_valid <= 1'b1;
    boot_pw_data <= d;
    @(posedge clock);
    boot_pw_valid <= 1'b0;
    @(negedge clock);
    `CHK("boot_open", exp, boot_open)
  endtask
  task automatic pulse_reset;
    @(posedge clock);
    rst_b <= 1'b0;
    @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    `CHK("locked", 1'b1, seg_a_locked)
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    `CHK("locked", 1'b1, seg_a_locked)
    run(0, OP_PROG_BYTE, 16'h2001, 16'hBEEF, 0, 16'h2001);
    run(0, OP_PROG_WORD, 16'h2002, 16'hBEEF, 0, 16'h2002);
    run(0, OP_PROG_WORD, 16'h2003, 16'hBEEF, 1, 0);
    run(0, OP_PROG_BYTE, 16'h0FFF, 16'h0011, 1, 0);
    run(0, 3'h6, 16'h2000, 0, 1, 0);
    run(0, OP_ERASE_SEG, 16'h23FF, 0, 0, 16'h2200);
    run(0, OP_ERASE_SEG, 16'h11F0, 0, 0, 16'h1100);
    run(1, OP_ERASE_SEG, 16'h1045, 0, 0, 16'h1040);
    run(1, OP_ERASE_SEG, 16'h10BF, 0, 0, 16'h1080);
    run(0, OP_PROG_BYTE, 16'h10C4, 16'h0012, 1, 0);
    run(0, OP_ERASE_SEG, 16'h10D0, 0, 1, 0);
    run(0, OP_ERASE_MASS, 16'h1100, 0, 1, 0);
    run(0, OP_ERASE_MAIN, 16'h1100, 0, 0, 16'hFFFF);
    @(posedge clock);
    seg_a_unlock <= 1'b1;
    @(posedge clock);
    seg_a_unlock <= 1'b0;
    @(negedge clock);
    `CHK("locked", 1'b0, seg_a_locked)
    run(1, OP_PROG_WORD, 16'h10C4, 16'h1234, 0, 16'h10C4);
    run(0, OP_ERASE_MASS, 16'h1100, 0, 0, 16'hFFFF);
    @(posedge clock);
    seg_a_unlock <= 1'b1;
    seg_a_lock <= 1'b1;
    @(posedge clock);
    seg_a_unlock <= 1'b0;
    seg_a_lock <= 1'b0;
    @(negedge clock);
    `CHK("locked", 1'b1, seg_a_locked)
    run(1, OP_ERASE_SEG, 16'h10C0, 0, 1, 0);
    pulse_reset();
    run(2, OP_READ, 16'h2000, 0, 1, 0);
    pw(16'h1111, 1'b0);
    pw(16'h3C5A, 1'b1);
    run(2, OP_READ, 16'h10FE, 0, 0, 16'h10FE);
    `CHK("rdata", 16'hA5FE, resp_rdata)
    `CHK("tag_empty", 1'b1, resp_tag_empty)
    run(2, OP_READ, 16'h2003, 0, 0, 16'h2003);
    `CHK("tag_empty", 1'b0, resp_tag_empty)
    for (int m = 0; m < 4; m++) begin
      @(posedge clock);
      margin_select <= 2'(m);
      @(posedge clock);
      @(negedge clock);
      `CHK("arr_margin", 2'(m), arr_margin)
    end
    conclude();
  end
endmodule
